// file: include/iafe_map.vh
// Register offsets, field positions, reset values and decimator sizing for the front end.
`ifndef IAFE_MAP_VH
`define IAFE_MAP_VH

// Register byte offsets (word aligned).
`define IAFE_STATUS_OFS     8'h00
`define IAFE_INT_STAT_OFS   8'h04
`define IAFE_INT_MASK_OFS   8'h08
`define IAFE_CLOCK_OFS      8'h0c
`define IAFE_CH0_CFG_OFS    8'h10
`define IAFE_CH1_CFG_OFS    8'h14
`define IAFE_CH2_CFG_OFS    8'h18
`define IAFE_GAIN_OFS       8'h1c
`define IAFE_DATA0_OFS      8'h20
`define IAFE_DATA1_OFS      8'h24
`define IAFE_DATA2_OFS      8'h28

// Status fields.
`define IAFE_ST_FAULT_BIT   0
`define IAFE_ST_LIVE_BIT    1

// Interrupt status and mask fields.
`define IAFE_IRQ_FAULT_BIT  0
`define IAFE_IRQ_DRDY_LSB   1

// Clock register fields and reset values.
`define IAFE_CLK_DIV_LSB    0
`define IAFE_CLK_SS_BIT     2
`define IAFE_CLK_DIV_RST    2'h0
`define IAFE_CLK_SS_RST     1'h1

// Divider half periods in main clock cycles for ratios 2, 4, 8 and 12.
`define IAFE_HALF_DIV2      3'h1
`define IAFE_HALF_DIV4      3'h2
`define IAFE_HALF_DIV8      3'h4
`define IAFE_HALF_DIV12     3'h6

// Resonator half period in modulator cycles, base value.
`define IAFE_RES_HALF_BASE  2'h2
`define IAFE_LFSR_SEED      8'h5a

// Input source codes.
`define IAFE_SRC_PINS       2'h0
`define IAFE_SRC_HIGH_SIDE_GROUND       2'h1
`define IAFE_SRC_TEST_POS   2'h2
`define IAFE_SRC_TEST_NEG   2'h3

// Gain field spacing and the smallest code that needs the precharge buffer (gain 8).
`define IAFE_GAIN_STRIDE    4
`define IAFE_GAIN_RST       3'h0
`define IAFE_GAIN_PRECHG    3'h3

// Sinc3 decimator: oversampling ratio 128, result width 3*7+1.
`define IAFE_OSR_LOG2       7
`define IAFE_RES_W          22

`endif

// file: rtl/iafe_sinc3_decim.v
// Third order sinc decimator turning one received bitstream into conversion results.
`timescale 1ns/100ps
`include "iafe_map.vh"

module iafe_sinc3_decim (
    input  wire                      ref_clk,
    input  wire                      reset,
    input  wire                      sample_en,
    input  wire                      bit_in,
    output reg  [`IAFE_RES_W-1:0]    result_reg,
    output reg                       result_valid_reg
);
    reg  [`IAFE_RES_W-1:0]   int1_reg;
    reg  [`IAFE_RES_W-1:0]   int2_reg;
    reg  [`IAFE_RES_W-1:0]   int3_reg;
    reg  [`IAFE_RES_W-1:0]   dly1_reg;
    reg  [`IAFE_RES_W-1:0]   dly2_reg;
    reg  [`IAFE_RES_W-1:0]   dly3_reg;
    reg  [`IAFE_OSR_LOG2-1:0] dec_cnt_reg;
    wire [`IAFE_RES_W-1:0]   comb1;
    wire [`IAFE_RES_W-1:0]   comb2;
    wire [`IAFE_RES_W-1:0]   comb3;
    wire                     dec_point;

    // Comb stages work at the decimated rate; wraparound arithmetic is intended.
    assign comb1     = int3_reg - dly1_reg;
    assign comb2     = comb1 - dly2_reg;
    assign comb3     = comb2 - dly3_reg;
    assign dec_point = sample_en && (&dec_cnt_reg);

    // Integrators run at the modulator rate, combs once every OSR samples.
    always @(posedge ref_clk) begin
        if (reset) begin
            int1_reg         <= {`IAFE_RES_W{1'b0}};
            int2_reg         <= {`IAFE_RES_W{1'b0}};
            int3_reg         <= {`IAFE_RES_W{1'b0}};
            dly1_reg         <= {`IAFE_RES_W{1'b0}};
            dly2_reg         <= {`IAFE_RES_W{1'b0}};
            dly3_reg         <= {`IAFE_RES_W{1'b0}};
            dec_cnt_reg      <= {`IAFE_OSR_LOG2{1'b0}};
            result_reg       <= {`IAFE_RES_W{1'b0}};
            result_valid_reg <= 1'b0;
        end else begin
            result_valid_reg <= dec_point;
            if (sample_en) begin
                int1_reg    <= int1_reg + {{(`IAFE_RES_W-1){1'b0}}, bit_in};
                int2_reg    <= int2_reg + int1_reg;
                int3_reg    <= int3_reg + int2_reg;
                dec_cnt_reg <= dec_cnt_reg + 1'b1;
            end
            if (dec_point) begin
                dly1_reg   <= int3_reg;
                dly2_reg   <= comb1;
                dly3_reg   <= comb2;
                result_reg <= comb3;
            end
        end
    end
endmodule

// file: rtl/iafe_front_end_ctrl.v
// Digital control of the isolated three channel front end with its AHB-Lite register slave.
// Behaviour
// R1: Latch converter supply fault as status bit.
// R2: Fault bit stays high until status read.
// R3: Status read clears the latched fault bit.
// R4: Host confirms supply with two status reads.
// R5: Per channel two bit input selector field.
// R6: Four sources: pins, ground, test plus/minus.
// R7: Independent three bit gain code per channel.
// R8: Precharge buffer on for gain eight upward.
// R9: Ones sent as carrier burst, zeros silent.
// R10: Received bitstream decimated by sinc filter.
// R11: Spread spectrum resonator clock tied to modulator.
// R12: Modulator clock divides main clock, default two.
// R13: Codes select ratios 2, 4, 8, 12.
// R14: Selector codes map pins, ground, plus, minus.
`timescale 1ns/100ps
`include "iafe_map.vh"

module iafe_front_end_ctrl (
    input  wire          ref_clk,
    input  wire          reset,
    input  wire          hsel,
    input  wire [31:0]   haddr,
    input  wire [1:0]    htrans,
    input  wire          hwrite,
    input  wire [2:0]    hsize,
    input  wire [31:0]   hwdata,
    input  wire          hready,
    output reg  [31:0]   hrdata,
    output reg           hreadyout,
    output reg           hresp,
    input  wire          supply_fail_in,
    input  wire [2:0]    mod_bits_in,
    input  wire [2:0]    ook_rx_in,
    output reg           modulator_clock,
    output reg           resonator_clock,
    output reg  [2:0]    ook_burst_en,
    output reg  [5:0]    input_source_select,
    output reg  [8:0]    channel_gain_code,
    output reg  [2:0]    precharge_en,
    output reg           irq
);
    // Pin synchronisers: supply fault, modulator bits and barrier receiver outputs.
    reg  [6:0]                sync1_reg;
    reg  [6:0]                sync2_reg;
    // Register file.
    reg                       supply_fault_flag_reg;
    reg  [3:0]                int_stat_reg;
    reg  [3:0]                int_mask_reg;
    reg  [1:0]                clk_div_reg;
    reg                       ss_en_reg;
    reg  [5:0]                src_sel_reg;
    reg  [8:0]                gain_reg;
    reg  [3*`IAFE_RES_W-1:0]  data_reg;
    // Bus state.
    reg                       wr_pend_reg;
    reg                       rd_pend_reg;
    reg  [7:0]                addr_reg;
    // Clock generation.
    reg  [2:0]                div_cnt_reg;
    reg  [2:0]                half_cur_reg;
    reg  [1:0]                res_cnt_reg;
    reg  [7:0]                lfsr_reg;
    reg                       fail_prev_reg;
    reg                       mod_tick_reg;
    reg  [31:0]               rd_next;
    reg  [2:0]                half_next;
    reg  [3:0]                int_set_next;
    wire [1:0]                res_half;
    wire [3*`IAFE_RES_W-1:0]  dec_result;
    wire [2:0]                dec_valid;
    wire                      fail_sync;
    wire [2:0]                mod_sync;
    wire [2:0]                rx_sync;
    wire                      addr_phase;
    wire [7:0]                cur_addr;
    // Loop indices, one per process.
    integer                   i;
    integer                   wr_i;
    integer                   pc_i;

    assign fail_sync  = sync2_reg[0];
    assign mod_sync   = sync2_reg[3:1];
    assign rx_sync    = sync2_reg[6:4];
    assign addr_phase = hsel && hready && htrans[1];
    assign cur_addr   = haddr[7:0];

    // Two flip-flop synchronisers for every pin input.
    // Only stage two feeds logic.
    always @(posedge ref_clk) begin
        if (reset) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end else begin
            sync1_reg <= {ook_rx_in, mod_bits_in, supply_fail_in};
            sync2_reg <= sync1_reg;
        end
    end

    // R13: divider ratio decode
    always @* begin
        case (clk_div_reg)
            2'h0:    half_next = `IAFE_HALF_DIV2;
            2'h1:    half_next = `IAFE_HALF_DIV4;
            2'h2:    half_next = `IAFE_HALF_DIV8;
            default: half_next = `IAFE_HALF_DIV12;
        endcase
    end

    // R12: modulator clock divider
    // A new ratio loads only at a half period boundary, so every level stays whole.
    always @(posedge ref_clk) begin
        if (reset) begin
            div_cnt_reg     <= 3'h0;
            half_cur_reg    <= `IAFE_HALF_DIV2;
            modulator_clock <= 1'b0;
            mod_tick_reg    <= 1'b0;
        end else begin
            mod_tick_reg <= 1'b0;
            if (div_cnt_reg + 3'h1 >= half_cur_reg) begin
                div_cnt_reg     <= 3'h0;
                half_cur_reg    <= half_next;
                modulator_clock <= ~modulator_clock;
                mod_tick_reg    <= ~modulator_clock;
            end else begin
                div_cnt_reg <= div_cnt_reg + 3'h1;
            end
        end
    end

    // R11: spread spectrum resonator
    // The half period is two or three modulator cycles, picked by an LFSR that steps at each resonator toggle.
    // Spread off: fixed half of two.
    assign res_half = ss_en_reg ? (`IAFE_RES_HALF_BASE + {1'b0, lfsr_reg[0]})
                                : `IAFE_RES_HALF_BASE;

    always @(posedge ref_clk) begin
        if (reset) begin
            res_cnt_reg     <= 2'h0;
            resonator_clock <= 1'b0;
            lfsr_reg        <= `IAFE_LFSR_SEED;
        end else if (mod_tick_reg) begin
            if (res_cnt_reg + 2'h1 >= res_half) begin
                res_cnt_reg     <= 2'h0;
                resonator_clock <= ~resonator_clock;
                lfsr_reg        <= {lfsr_reg[6:0],
                                    lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
            end else begin
                res_cnt_reg <= res_cnt_reg + 2'h1;
            end
        end
    end

    // R9: on off keying
    // Each modulator bit gates the barrier carrier for one modulator period.
    // The carrier itself is analog.
    always @(posedge ref_clk) begin
        if (reset) begin
            ook_burst_en <= 3'h0;
        end else if (mod_tick_reg) begin
            ook_burst_en <= mod_sync;
        end
    end

    // R10: sinc decimation per channel
    // One strobe keeps channels aligned.
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
            iafe_sinc3_decim u_decim (
                .ref_clk          (ref_clk),
                .reset            (reset),
                .sample_en        (mod_tick_reg),
                .bit_in           (rx_sync[ch]),
                .result_reg       (dec_result[ch*`IAFE_RES_W +: `IAFE_RES_W]),
                .result_valid_reg (dec_valid[ch])
            );

            // Results are held for the host until the next decimation point.
            always @(posedge ref_clk) begin
                if (reset) begin
                    data_reg[ch*`IAFE_RES_W +: `IAFE_RES_W] <= {`IAFE_RES_W{1'b0}};
                end else if (dec_valid[ch]) begin
                    data_reg[ch*`IAFE_RES_W +: `IAFE_RES_W] <=
                        dec_result[ch*`IAFE_RES_W +: `IAFE_RES_W];
                end
            end
        end
    endgenerate

    // Read multiplexer, evaluated in the read wait cycle after any pending write.
    always @* begin
        rd_next = 32'h0000_0000;
        case (addr_reg)
            `IAFE_STATUS_OFS: begin
                rd_next[`IAFE_ST_FAULT_BIT] = supply_fault_flag_reg;
                rd_next[`IAFE_ST_LIVE_BIT]  = fail_sync;
            end
            `IAFE_INT_STAT_OFS: rd_next[3:0] = int_stat_reg;
            `IAFE_INT_MASK_OFS: rd_next[3:0] = int_mask_reg;
            `IAFE_CLOCK_OFS: begin
                rd_next[`IAFE_CLK_DIV_LSB +: 2] = clk_div_reg;
                rd_next[`IAFE_CLK_SS_BIT]       = ss_en_reg;
            end
            `IAFE_CH0_CFG_OFS: rd_next[1:0] = src_sel_reg[1:0];
            `IAFE_CH1_CFG_OFS: rd_next[1:0] = src_sel_reg[3:2];
            `IAFE_CH2_CFG_OFS: rd_next[1:0] = src_sel_reg[5:4];
            `IAFE_GAIN_OFS: begin
                for (i = 0; i < 3; i = i + 1) begin
                    rd_next[i*`IAFE_GAIN_STRIDE +: 3] = gain_reg[i*3 +: 3];
                end
            end
            `IAFE_DATA0_OFS: rd_next[`IAFE_RES_W-1:0] = data_reg[0 +: `IAFE_RES_W];
            `IAFE_DATA1_OFS: rd_next[`IAFE_RES_W-1:0] = data_reg[`IAFE_RES_W +: `IAFE_RES_W];
            `IAFE_DATA2_OFS: rd_next[`IAFE_RES_W-1:0] = data_reg[2*`IAFE_RES_W +: `IAFE_RES_W];
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Bus phases: writes complete without wait, reads insert one wait cycle.
    // The wait lets a read see a fresh write.
    always @(posedge ref_clk) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            hreadyout   <= 1'b1;
            hrdata      <= 32'h0000_0000;
            hresp       <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_pend_reg) begin
                rd_pend_reg <= 1'b0;
                hreadyout   <= 1'b1;
                hrdata      <= rd_next;
            end else if (addr_phase) begin
                addr_reg    <= {cur_addr[7:2], 2'b00};
                wr_pend_reg <= hwrite;
                rd_pend_reg <= ~hwrite;
                hreadyout   <= hwrite;
            end else begin
                wr_pend_reg <= 1'b0;
            end
            if (wr_pend_reg && !addr_phase) begin
                wr_pend_reg <= 1'b0;
            end
        end
    end

    // Events for the interrupt status: a new supply failure and each fresh result.
    always @* begin
        int_set_next                     = 4'h0;
        int_set_next[`IAFE_IRQ_FAULT_BIT] = fail_sync && !fail_prev_reg;
        int_set_next[`IAFE_IRQ_DRDY_LSB +: 3] = dec_valid;
    end

    // R1: latch supply fault
    // R2: hold until read
    // R3: read clears fault
    // A failure seen in the clearing cycle wins, so no fault is lost.
    // The read returns the flag before clearing.
    always @(posedge ref_clk) begin
        if (reset) begin
            supply_fault_flag_reg <= 1'b0;
            fail_prev_reg         <= 1'b0;
        end else begin
            fail_prev_reg <= fail_sync;
            if (fail_sync) begin
                supply_fault_flag_reg <= 1'b1;
            end else if (rd_pend_reg && addr_reg == `IAFE_STATUS_OFS) begin
                supply_fault_flag_reg <= 1'b0;
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins over clear.
    // The line lags status by one cycle.
    always @(posedge ref_clk) begin
        if (reset) begin
            int_stat_reg <= 4'h0;
            irq          <= 1'b0;
        end else begin
            if (wr_pend_reg && addr_reg == `IAFE_INT_STAT_OFS) begin
                int_stat_reg <= (int_stat_reg & ~hwdata[3:0]) | int_set_next;
            end else begin
                int_stat_reg <= int_stat_reg | int_set_next;
            end
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // R5: per channel selector
    // R7: per channel gain
    // R12: divide by two default
    always @(posedge ref_clk) begin
        if (reset) begin
            int_mask_reg <= 4'h0;
            clk_div_reg  <= `IAFE_CLK_DIV_RST;
            ss_en_reg    <= `IAFE_CLK_SS_RST;
            src_sel_reg  <= {3{`IAFE_SRC_PINS}};
            gain_reg     <= {3{`IAFE_GAIN_RST}};
        end else if (wr_pend_reg) begin
            case (addr_reg)
                `IAFE_INT_MASK_OFS: int_mask_reg <= hwdata[3:0];
                `IAFE_CLOCK_OFS: begin
                    clk_div_reg <= hwdata[`IAFE_CLK_DIV_LSB +: 2];
                    ss_en_reg   <= hwdata[`IAFE_CLK_SS_BIT];
                end
                `IAFE_CH0_CFG_OFS: src_sel_reg[1:0] <= hwdata[1:0];
                `IAFE_CH1_CFG_OFS: src_sel_reg[3:2] <= hwdata[1:0];
                `IAFE_CH2_CFG_OFS: src_sel_reg[5:4] <= hwdata[1:0];
                `IAFE_GAIN_OFS: begin
                    for (wr_i = 0; wr_i < 3; wr_i = wr_i + 1) begin
                        gain_reg[wr_i*3 +: 3] <= hwdata[wr_i*`IAFE_GAIN_STRIDE +: 3];
                    end
                end
                default: int_mask_reg <= int_mask_reg;
            endcase
        end
    end

    // R6: four source routing
    // R14: selector code mapping
    // Codes pass straight to the analog switch: 0 pins, 1 ground, 2 test plus, 3 test minus.
    // R8: precharge from gain
    always @(posedge ref_clk) begin
        if (reset) begin
            input_source_select <= {3{`IAFE_SRC_PINS}};
            channel_gain_code   <= {3{`IAFE_GAIN_RST}};
            precharge_en        <= 3'h0;
        end else begin
            input_source_select <= src_sel_reg;
            channel_gain_code   <= gain_reg;
            for (pc_i = 0; pc_i < 3; pc_i = pc_i + 1) begin
                precharge_en[pc_i] <= (gain_reg[pc_i*3 +: 3] >= `IAFE_GAIN_PRECHG);
            end
        end
    end
endmodule

// file: testbench/iafe_far_model.sv
// Behavioural isolated side: supply monitor, modulators and barrier receivers.
`timescale 1ns/100ps
module iafe_far_model (
    input  wire       ref_clk,
    input  wire       modulator_clock,
    input  wire [2:0] ook_burst_en,
    input  wire       fail_req,
    input  wire [2:0] bits_req,
    output wire       supply_fail_in,
    output reg  [2:0] mod_bits_in,
    output reg  [2:0] ook_rx_in
);
    reg [2:0] barrier_q;

    // The converter monitor reports the failure level the bench asks for.
    assign supply_fail_in = fail_req;

    // Start from silence so no unknown crosses the barrier.
    initial begin
        mod_bits_in = 3'h0;
        ook_rx_in = 3'h0;
        barrier_q = 3'h0;
    end

    always @(negedge modulator_clock) begin
        mod_bits_in <= bits_req;
    end

    always @(posedge ref_clk) begin
        barrier_q <= ook_burst_en;
        ook_rx_in <= barrier_q;
    end
endmodule

// file: testbench/iafe_front_end_chk.sv
// Port-level assertions for the front end control block.
`timescale 1ns/100ps
module iafe_front_end_chk (
    input wire        ref_clk,
    input wire        reset,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        supply_fail_in,
    input wire [2:0]  mod_bits_in,
    input wire [2:0]  ook_rx_in,
    input wire        modulator_clock,
    input wire        resonator_clock,
    input wire [2:0]  ook_burst_en,
    input wire [5:0]  input_source_select,
    input wire [8:0]  channel_gain_code,
    input wire [2:0]  precharge_en,
    input wire        irq
);
    reg        mc_d;
    reg        clk_wr;
    reg        gain_wr_q;
    reg        sel_wr_q;
    reg  [1:0] sel_ch_q;
    reg  [3:0] run;
    reg  [3:0] fail_hi;
    wire       take = hsel && hready && htrans[1];
    wire       mod_chg = modulator_clock != mc_d;
    wire [2:0] pre_exp = {channel_gain_code[8:6] > 3'h2, channel_gain_code[5:3] > 3'h2,
                          channel_gain_code[2:0] > 3'h2};

    // Level lengths of the modulator clock, pending writes and the fault pin history.
    always @(posedge ref_clk) begin
        mc_d <= modulator_clock;
        gain_wr_q <= take && hwrite && haddr[7:0] == 8'h1c;
        sel_wr_q <= take && hwrite && haddr[7:4] == 4'h1 && haddr[3:2] != 2'h3;
        sel_ch_q <= haddr[3:2];
        if (reset) begin
            run <= 4'h0;
            fail_hi <= 4'h0;
            clk_wr <= 1'b0;
        end else begin
            run <= mod_chg ? 4'h1 : (run == 4'h0) ? 4'h0 : run + 4'h1;
            fail_hi <= !supply_fail_in ? 4'h0 : (fail_hi == 4'hf) ? fail_hi : fail_hi + 4'h1;
            clk_wr <= clk_wr || (take && hwrite && haddr[7:0] == 8'h0c);
        end
    end

    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    fault_seen_a: assert property (
        take && !hwrite && haddr[7:0] == 8'h00 && fail_hi > 4'h3
        |=> !hreadyout ##1 hreadyout && hrdata[1:0] == 2'b11) else $error("fault not read");
    default_div_a: assert property (
        mod_chg && run != 4'h0 && !clk_wr |-> run == 4'h1) else $error("default ratio");
    half_period_a: assert property (
        mod_chg && run != 4'h0 |-> run inside {4'h1, 4'h2, 4'h4, 4'h6}) else $error("ratio");
    precharge_a: assert property (
        $stable(channel_gain_code) |-> precharge_en == pre_exp) else $error("precharge");
    gain_write_a: assert property (
        gain_wr_q |=> ##1 channel_gain_code == {$past(hwdata[10:8], 2), $past(hwdata[6:4], 2),
        $past(hwdata[2:0], 2)}) else $error("gain write");
    src_write_a: assert property (
        sel_wr_q |=> ##1 input_source_select[{$past(sel_ch_q, 2), 1'b0} +: 2]
        == $past(hwdata[1:0], 2)) else $error("source write");
    burst_value_a: assert property (
        $rose(modulator_clock) && $stable(mod_bits_in) && $past(mod_bits_in, 2) == mod_bits_in
        && $past(mod_bits_in, 3) == mod_bits_in |=> ook_burst_en == $past(mod_bits_in))
        else $error("burst value");
    burst_timing_a: assert property (
        $changed(ook_burst_en) |-> $past(modulator_clock) && !$past(modulator_clock, 2))
        else $error("burst timing");
    resonator_sync_a: assert property (
        $changed(resonator_clock) |-> $past(modulator_clock) && !$past(modulator_clock, 2))
        else $error("resonator timing");
endmodule

bind iafe_front_end_ctrl iafe_front_end_chk u_chk (.*);

// file: testbench/tb.sv
// Self-checking bench for the front end control block.
`timescale 1ns/100ps
`include "iafe_map.vh"
`define CHK(nm, ex, got) begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
        $display("ERROR %s expected %h seen %h", nm, ex, got); \
        error_cnt++; \
    end \
end

module tb;
    reg          ref_clk = 1'b0;
    reg          reset = 1'b1;
    reg          hsel = 1'b0;
    reg  [31:0]  haddr = 32'h0;
    reg  [1:0]   htrans = 2'h0;
    reg          hwrite = 1'b0;
    reg  [31:0]  hwdata = 32'h0;
    reg          fail_req = 1'b0;
    reg  [2:0]   bits_req = 3'h0;
    reg          rd_dph = 1'b0;
    reg  [8:0]   g;
    reg  [31:0]  gw;
    reg  [63:0]  expv;
    reg  [63:0]  exp_q[$];
    wire [31:0]  hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         supply_fail_in;
    wire         modulator_clock;
    wire         irq;
    wire [2:0]   mod_bits_in;
    wire [2:0]   ook_rx_in;
    wire [2:0]   ook_burst_en;
    wire [2:0]   precharge_en;
    wire [5:0]   input_source_select;
    wire [8:0]   channel_gain_code;
    integer      error_cnt = 0;
    integer      samples_checked = 0;
    integer      seed = 32'h1c5a;
    integer      i;
    integer      k;
    integer      n;

    // Main clock at 200 MHz.
    always #2.5 ref_clk = ~ref_clk;

    iafe_front_end_ctrl uut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .supply_fail_in(supply_fail_in), .mod_bits_in(mod_bits_in), .ook_rx_in(ook_rx_in),
        .modulator_clock(modulator_clock), .resonator_clock(), .ook_burst_en(ook_burst_en),
        .input_source_select(input_source_select), .channel_gain_code(channel_gain_code),
        .precharge_en(precharge_en));

    iafe_far_model far (.ref_clk(ref_clk), .modulator_clock(modulator_clock),
        .ook_burst_en(ook_burst_en), .fail_req(fail_req), .bits_req(bits_req),
        .supply_fail_in(supply_fail_in), .mod_bits_in(mod_bits_in), .ook_rx_in(ook_rx_in));

    // Data phase monitor: the oldest noted read is compared where hready is high.
    always @(posedge ref_clk) begin
        if (rd_dph && hreadyout === 1'b1) begin
            expv = exp_q.pop_front();
            `CHK("hrdata", expv[31:0], hrdata & expv[63:32])
            `CHK("hresp", 1'b0, hresp)
        end
        if (hreadyout === 1'b1)
            rd_dph = hsel && htrans[1] && !hwrite;
    end

    task report_and_stop;
        begin
            $display("Mismatches %0d, comparisons %0d", error_cnt, samples_checked);
            if (error_cnt == 0 && samples_checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // Waits for hready under a bound; running out ends the run.
    task automatic wait_ready;
        integer t;
        begin
            t = 0;
            @(posedge ref_clk);
            while (hreadyout !== 1'b1 && t < 20) begin
                t++;
                @(posedge ref_clk);
            end
            if (hreadyout !== 1'b1) begin
                error_cnt++;
                report_and_stop;
            end
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
        begin
            hsel <= 1'b1;
            haddr <= {24'h0, adr};
            hwrite <= wr;
            htrans <= 2'h2;
            wait_ready;
            htrans <= 2'h0;
            hwdata <= wr ? dat : 32'h0;
            wait_ready;
        end
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
        begin
            exp_q.push_back({m, e & m});
            bus(1'b0, adr, 32'h0);
        end
    endtask

    // Counts the cycles of one modulator clock level.
    task automatic half_len(output integer len);
        logic v;
        begin
            v = modulator_clock;
            len = 0;
            while (modulator_clock === v && len < 40) begin
                len++;
                @(posedge ref_clk);
            end
        end
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(`IAFE_CLOCK_OFS, {29'h0, `IAFE_CLK_SS_RST, `IAFE_CLK_DIV_RST});
        rd(`IAFE_GAIN_OFS, 32'h0);
        bus(1'b1, 8'h3c, $random(seed));
        rd(8'h3c, 32'h0);
        for (k = 0; k < 8; k++) begin
            n = $random(seed);
            g = {n[2:0], 3'(7 - k), k[2:0]};
            gw = {21'h0, g[8:6], 1'b0, g[5:3], 1'b0, g[2:0]};
            bus(1'b1, `IAFE_GAIN_OFS, (n & 32'hfffff888) | gw);
            rd(`IAFE_GAIN_OFS, gw);
            `CHK("gain", g, channel_gain_code)
            `CHK("precharge", {g[8:6] > 3'h2, g[5:3] > 3'h2, g[2:0] > 3'h2}, precharge_en)
        end
        for (k = 0; k < 4; k++) begin
            for (i = 0; i < 3; i++)
                bus(1'b1, `IAFE_CH0_CFG_OFS + 8'(4 * i), 32'hfffffffc | 32'((k + i) % 4));
            for (i = 0; i < 3; i++)
                rd(`IAFE_CH0_CFG_OFS + 8'(4 * i), 32'((k + i) % 4));
            `CHK("source", {2'((k + 2) % 4), 2'((k + 1) % 4), 2'(k)}, input_source_select)
        end
        for (k = 0; k < 4; k++) begin
            bus(1'b1, `IAFE_CLOCK_OFS, {29'h0, 1'b1, 2'(k)});
            rd(`IAFE_CLOCK_OFS, {29'h0, 1'b1, 2'(k)});
            repeat (3) half_len(n);
            `CHK("half period", (k == 0) ? 1 : (k == 3) ? 6 : 2 * k, n)
        end
        bus(1'b1, `IAFE_INT_MASK_OFS, 32'h1);
        fail_req <= 1'b1;
        repeat (8) @(posedge ref_clk);
        `CHK("irq on", 1'b1, irq)
        rd(`IAFE_STATUS_OFS, 32'h3);
        rd(`IAFE_STATUS_OFS, 32'h3);
        fail_req <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(`IAFE_STATUS_OFS, 32'h1);
        rd(`IAFE_STATUS_OFS, 32'h0);
        rd(`IAFE_INT_STAT_OFS, 32'h1, 32'h1);
        bus(1'b1, `IAFE_INT_STAT_OFS, 32'h1);
        rd(`IAFE_INT_STAT_OFS, 32'h0, 32'h1);
        `CHK("irq off", 1'b0, irq)
        bus(1'b1, `IAFE_INT_MASK_OFS, 32'h0);
        fail_req <= 1'b1;
        repeat (8) @(posedge ref_clk);
        `CHK("irq masked", 1'b0, irq)
        rd(`IAFE_INT_STAT_OFS, 32'h1, 32'h1);
        fail_req <= 1'b0;
        bus(1'b1, `IAFE_CLOCK_OFS, 32'h4);
        bits_req <= 3'h5;
        repeat (1600) @(posedge ref_clk);
        `CHK("burst", 3'h5, ook_burst_en)
        rd(`IAFE_DATA0_OFS, 32'h200000);
        rd(`IAFE_DATA1_OFS, 32'h0);
        rd(`IAFE_DATA2_OFS, 32'h200000);
        rd(`IAFE_INT_STAT_OFS, 32'he, 32'he);
        @(posedge ref_clk);
        report_and_stop;
    end
endmodule
